// File: rtl/timer2_pkg.sv
// Constants, field layouts and carrier types for the Timer 2 block
package timer2_pkg;

  // Register addresses on the special-function-register bus
  localparam logic [7:0] ADDR_CLK_SEL = 8'h8f;
  localparam logic [7:0] ADDR_CTL     = 8'hc8;
  localparam logic [7:0] ADDR_RLD_LO  = 8'hca;
  localparam logic [7:0] ADDR_RLD_HI  = 8'hcb;
  localparam logic [7:0] ADDR_CNT_LO  = 8'hcc;
  localparam logic [7:0] ADDR_CNT_HI  = 8'hcd;

  // Reset values
  localparam logic [7:0] CLK_SEL_RESET = 8'h00;
  localparam logic [7:0] CTL_RESET     = 8'h00;
  localparam logic [7:0] BYTE_RESET    = 8'h00;

  // Control register bit positions
  localparam int CTL_HI_FLAG_BIT = 7;
  localparam int CTL_LO_FLAG_BIT = 6;
  localparam int CTL_UNUSED_BIT  = 1;

  // Count limits
  localparam logic [7:0] BYTE_MAX     = 8'hff;
  localparam logic [3:0] DIV12_LAST   = 4'hb;
  localparam logic [5:0] DIV48_LAST   = 6'h2f;
  localparam logic [1:0] DIV4_LAST    = 2'h3;
  localparam logic [2:0] EXT_DIV_LAST = 3'h7;

  // Timer 0/1 prescale codes
  localparam logic [1:0] PRESCALE_DIV12 = 2'h0;
  localparam logic [1:0] PRESCALE_DIV4  = 2'h1;
  localparam logic [1:0] PRESCALE_DIV48 = 2'h2;
  localparam logic [1:0] PRESCALE_EXT8  = 2'h3;

  // Register bus request
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_t;

  // Shared clock-select register, bit 7 down to bit 0
  typedef struct packed {
    logic       third_timer_hi_clock_select;
    logic       third_timer_lo_clock_select;
    logic       hi_byte_clock_select;
    logic       lo_byte_clock_select;
    logic       timer_one_clock_select;
    logic       timer_zero_clock_select;
    logic [1:0] prescale_code;
  } clk_sel_t;

  // Timer 2 control register, bit 7 down to bit 0
  typedef struct packed {
    logic hi_overflow_flag;
    logic lo_overflow_flag;
    logic lo_overflow_irq_enable;
    logic frame_capture_enable;
    logic split_mode_enable;
    logic run_control;
    logic unused;
    logic external_clock_select;
  } ctl_t;

  // Count enables handed to the other timers
  typedef struct packed {
    logic t0;
    logic t1;
    logic t3_hi;
    logic t3_lo;
  } tick_t;

  // Whole state of the block
  typedef struct packed {
    clk_sel_t   clk_sel;
    ctl_t       ctl;
    logic [7:0] count_lo_byte;
    logic [7:0] count_hi_byte;
    logic [7:0] reload_lo_byte;
    logic [7:0] reload_hi_byte;
    logic [3:0] div12_cnt;
    logic [5:0] div48_cnt;
    logic [2:0] ext_sync;
    logic [2:0] ext_cnt;
    logic       div12_tick;
    logic       div4_tick;
    logic       div48_tick;
    logic       ext8_tick;
    tick_t      ticks;
    logic       irq;
    logic [7:0] rdata;
  } state_t;

endpackage

// File: rtl/timer2_reload_sof_capture.sv
// Timer 2 with auto-reload, split and frame capture modes, plus the shared clock select
//
// Function
// - Non-split, non-capture: 16-bit count, on 0xffff wrap load reload and set high flag.
// - Interrupt request whenever timer interrupts are enabled and high flag is set.
// - Low flag also requests interrupt when its enable and timer interrupts are on.
// - Split without capture: two 8-bit counters, each reloads from its own reload byte.
// - Run bit gates whole timer in 16-bit; in split only high byte, low free.
// - Clock select 1 picks system clock; 0 picks sysclk/12 or external/8 by external select.
// - High clock select only matters in split; else low select clocks whole timer.
// - External clock is synchronised to system clock before divide-by-8 advances counts.
// - High flag on high byte wrap, low flag on every low byte wrap, any mode.
// - Hardware never clears either flag; software clears and inspects both.
// - Capture, not split: 16-bit free wrap; each frame pulse copies count into reload.
// - Capture and split: two 8-bit wrapping counters; frame pulse latches both bytes.
// - Control layout: flags, low enable, capture, split, run, bit 1 zero, external select.
// - Timer 0/1 prescaler: 00 sysclk/12, 01 sysclk/4, 10 sysclk/48, 11 external/8.
// - Timer 0/1 select: 1 system clock, 0 prescaled; ignored in pin counting mode.
// - Clock select bits 7 and 6 choose Timer 3 high and low byte clocks.
// - Bits 5,4 Timer 2 selects; 3,2 Timer 1/0 selects; 1:0 prescale code.
// - Reload bytes feed auto-reload, hold captured counts, and are software read/write.
`timescale 1ns/100ps
module timer2_reload_sof_capture
  import timer2_pkg::*;
(
  // Clock and reset
  input  wire logic     mclk,
  input  wire logic     rst_n,
  // Register bus
  input  wire sfr_req_t sfr,
  output logic [7:0]    rdata,
  // Frame detector and external oscillator
  input  wire logic     sof_pulse,
  input  wire logic     ext_osc,
  // Settings held by other blocks
  input  wire logic     timer_irq_enable,
  input  wire logic     timer_zero_counter_mode,
  input  wire logic     timer_one_counter_mode,
  input  wire logic     third_timer_split,
  input  wire logic     third_timer_ext_clock_select,
  // Results
  output logic          irq,
  output tick_t         ticks
);

  state_t     st_r;
  state_t     st_nxt;
  logic       lo_tick;
  logic       hi_tick;
  logic       lo_wrap;
  logic       hi_wrap;
  logic       capture;
  logic       ext_edge;
  logic       prescaled;
  logic       t3_lo_tick;
  logic [7:0] ctl_read;

  // Address match for a write strobe
  function automatic logic wr_hit(input sfr_req_t r, input logic [7:0] a);
    return r.wr && (r.addr == a);
  endfunction

  // Byte clock choice: system clock, else sysclk/12 or external/8
  function automatic logic clk_pick(input logic sel, input logic ext_sel,
                                    input logic ext8, input logic div12);
    if (sel) begin
      return 1'b1;
    end else if (ext_sel) begin
      return ext8;
    end else begin
      return div12;
    end
  endfunction

  // Next-state logic
  always_comb begin
    st_nxt  = st_r;
    lo_wrap = 1'b0;
    hi_wrap = 1'b0;
    capture = st_r.ctl.frame_capture_enable && sof_pulse;

    // System clock dividers
    st_nxt.div12_tick = (st_r.div12_cnt == DIV12_LAST);
    st_nxt.div12_cnt  = st_nxt.div12_tick ? 4'h0 : st_r.div12_cnt + 4'h1;
    st_nxt.div48_tick = (st_r.div48_cnt == DIV48_LAST);
    st_nxt.div4_tick  = (st_r.div48_cnt[1:0] == DIV4_LAST);
    st_nxt.div48_cnt  = st_nxt.div48_tick ? 6'h00 : st_r.div48_cnt + 6'h01;

    // External clock synchroniser and divide by 8
    st_nxt.ext_sync  = {st_r.ext_sync[1:0], ext_osc};
    ext_edge         = st_r.ext_sync[1] && !st_r.ext_sync[2];
    st_nxt.ext8_tick = ext_edge && (st_r.ext_cnt == EXT_DIV_LAST);
    if (ext_edge) begin
      st_nxt.ext_cnt = st_r.ext_cnt + 3'h1;
    end

    // Byte clocks; high select only counts in split mode
    lo_tick = clk_pick(st_r.clk_sel.lo_byte_clock_select, st_r.ctl.external_clock_select,
                       st_r.ext8_tick, st_r.div12_tick);
    hi_tick = st_r.ctl.split_mode_enable
              ? clk_pick(st_r.clk_sel.hi_byte_clock_select, st_r.ctl.external_clock_select,
                         st_r.ext8_tick, st_r.div12_tick)
              : lo_tick;

    // Counting
    if (!st_r.ctl.split_mode_enable) begin
      if (st_r.ctl.run_control && lo_tick) begin
        lo_wrap = (st_r.count_lo_byte == BYTE_MAX);
        hi_wrap = lo_wrap && (st_r.count_hi_byte == BYTE_MAX);
        {st_nxt.count_hi_byte, st_nxt.count_lo_byte} =
          {st_r.count_hi_byte, st_r.count_lo_byte} + 16'h0001;
        if (hi_wrap && !st_r.ctl.frame_capture_enable) begin
          st_nxt.count_hi_byte = st_r.reload_hi_byte;
          st_nxt.count_lo_byte = st_r.reload_lo_byte;
        end
      end
    end else begin
      if (lo_tick) begin
        lo_wrap = (st_r.count_lo_byte == BYTE_MAX);
        st_nxt.count_lo_byte = st_r.count_lo_byte + 8'h01;
        if (lo_wrap && !st_r.ctl.frame_capture_enable) begin
          st_nxt.count_lo_byte = st_r.reload_lo_byte;
        end
      end
      if (st_r.ctl.run_control && hi_tick) begin
        hi_wrap = (st_r.count_hi_byte == BYTE_MAX);
        st_nxt.count_hi_byte = st_r.count_hi_byte + 8'h01;
        if (hi_wrap && !st_r.ctl.frame_capture_enable) begin
          st_nxt.count_hi_byte = st_r.reload_hi_byte;
        end
      end
    end

    // Frame capture into the reload bytes
    if (capture) begin
      st_nxt.reload_lo_byte = st_r.count_lo_byte;
      st_nxt.reload_hi_byte = st_r.count_hi_byte;
    end

    // Software writes take the data bytes
    if (wr_hit(sfr, ADDR_CNT_LO)) begin
      st_nxt.count_lo_byte = sfr.wdata;
    end
    if (wr_hit(sfr, ADDR_CNT_HI)) begin
      st_nxt.count_hi_byte = sfr.wdata;
    end
    if (wr_hit(sfr, ADDR_RLD_LO)) begin
      st_nxt.reload_lo_byte = sfr.wdata;
    end
    if (wr_hit(sfr, ADDR_RLD_HI)) begin
      st_nxt.reload_hi_byte = sfr.wdata;
    end
    if (wr_hit(sfr, ADDR_CLK_SEL)) begin
      st_nxt.clk_sel = clk_sel_t'(sfr.wdata);
    end
    if (wr_hit(sfr, ADDR_CTL)) begin
      st_nxt.ctl        = ctl_t'(sfr.wdata);
      st_nxt.ctl.unused = 1'b0;
    end

    // Flags: hardware sets, as can a control write; a hardware set beats a same-cycle clear
    if (hi_wrap || capture) begin
      st_nxt.ctl.hi_overflow_flag = 1'b1;
    end
    if (lo_wrap) begin
      st_nxt.ctl.lo_overflow_flag = 1'b1;
    end

    // Interrupt request follows the flags
    st_nxt.irq = timer_irq_enable
                 && (st_nxt.ctl.hi_overflow_flag
                     || (st_nxt.ctl.lo_overflow_irq_enable
                         && st_nxt.ctl.lo_overflow_flag));

    // Timer 0/1 prescaler and selects
    case (st_r.clk_sel.prescale_code)
      PRESCALE_DIV12: prescaled = st_r.div12_tick;
      PRESCALE_DIV4:  prescaled = st_r.div4_tick;
      PRESCALE_DIV48: prescaled = st_r.div48_tick;
      default:        prescaled = st_r.ext8_tick;
    endcase
    st_nxt.ticks.t0 = !timer_zero_counter_mode
                      && (st_r.clk_sel.timer_zero_clock_select || prescaled);
    st_nxt.ticks.t1 = !timer_one_counter_mode
                      && (st_r.clk_sel.timer_one_clock_select || prescaled);

    // Timer 3 byte clocks
    t3_lo_tick = clk_pick(st_r.clk_sel.third_timer_lo_clock_select,
                          third_timer_ext_clock_select,
                          st_r.ext8_tick, st_r.div12_tick);
    st_nxt.ticks.t3_lo = t3_lo_tick;
    st_nxt.ticks.t3_hi = third_timer_split
                         ? clk_pick(st_r.clk_sel.third_timer_hi_clock_select,
                                    third_timer_ext_clock_select,
                                    st_r.ext8_tick, st_r.div12_tick)
                         : t3_lo_tick;

    // Read data, one cycle after the address
    ctl_read = st_r.ctl;
    ctl_read[CTL_UNUSED_BIT] = 1'b0;
    if (sfr.addr == ADDR_CLK_SEL) begin
      st_nxt.rdata = st_r.clk_sel;
    end else if (sfr.addr == ADDR_CTL) begin
      st_nxt.rdata = ctl_read;
    end else if (sfr.addr == ADDR_RLD_LO) begin
      st_nxt.rdata = st_r.reload_lo_byte;
    end else if (sfr.addr == ADDR_RLD_HI) begin
      st_nxt.rdata = st_r.reload_hi_byte;
    end else if (sfr.addr == ADDR_CNT_LO) begin
      st_nxt.rdata = st_r.count_lo_byte;
    end else if (sfr.addr == ADDR_CNT_HI) begin
      st_nxt.rdata = st_r.count_hi_byte;
    end else begin
      st_nxt.rdata = BYTE_RESET;
    end
  end

  // State register
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from flip-flops
  assign rdata = st_r.rdata;
  assign irq   = st_r.irq;
  assign ticks = st_r.ticks;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  // Checks
  a_wrap_reload16:
    assert property (!st_r.ctl.split_mode_enable && !st_r.ctl.frame_capture_enable
                     && st_r.ctl.run_control && lo_tick && !sfr.wr
                     && {st_r.count_hi_byte, st_r.count_lo_byte} == 16'hffff
                     |=> {st_r.count_hi_byte, st_r.count_lo_byte}
                         == $past({st_r.reload_hi_byte, st_r.reload_lo_byte})
                         && st_r.ctl.hi_overflow_flag && st_r.ctl.lo_overflow_flag)
    else $error("16-bit wrap did not reload or flag");

  a_irq_from_flags:
    assert property (timer_irq_enable && st_r.ctl.hi_overflow_flag && !sfr.wr
                     |=> irq)
    else $error("high flag set with interrupts on but no request");

  a_irq_has_cause:
    assert property (irq |-> $past(timer_irq_enable) && (st_r.ctl.hi_overflow_flag
                     || (st_r.ctl.lo_overflow_irq_enable && st_r.ctl.lo_overflow_flag)))
    else $error("interrupt request without an enabled flag");

  a_split_lo_free:
    assert property (st_r.ctl.split_mode_enable && !st_r.ctl.run_control && lo_tick
                     && !sfr.wr && st_r.count_lo_byte != BYTE_MAX
                     |=> st_r.count_lo_byte == $past(st_r.count_lo_byte) + 8'h01
                         && st_r.count_hi_byte == $past(st_r.count_hi_byte))
    else $error("split low byte not free running or high byte not held");

  a_div12_spacing:
    assert property (st_r.div12_tick |=> !st_r.div12_tick [*8] ##1 !st_r.div12_tick [*3]
                     ##1 st_r.div12_tick)
    else $error("divide by 12 enable not spaced by 12 cycles");

  a_flag_set_wins:
    assert property (lo_wrap && wr_hit(sfr, ADDR_CTL) |=> st_r.ctl.lo_overflow_flag)
    else $error("low flag lost to a same-cycle clear");

  a_flag_sticky:
    assert property (st_r.ctl.hi_overflow_flag && !wr_hit(sfr, ADDR_CTL)
                     |=> st_r.ctl.hi_overflow_flag)
    else $error("high flag cleared by hardware");

  a_capture_copy:
    assert property (st_r.ctl.frame_capture_enable && sof_pulse && !sfr.wr
                     |=> st_r.reload_lo_byte == $past(st_r.count_lo_byte)
                         && st_r.reload_hi_byte == $past(st_r.count_hi_byte))
    else $error("frame capture did not latch the count");

  a_ctl_bit1_zero:
    assert property (sfr.addr == ADDR_CTL |=> rdata[CTL_UNUSED_BIT] == 1'b0)
    else $error("control bit 1 read as one");

  a_pin_mode_ticks:
    assert property (timer_zero_counter_mode |=> !ticks.t0)
    else $error("timer 0 enable driven in pin counting mode");

  a_hold_when_stopped:
    assert property (!st_r.ctl.split_mode_enable && !st_r.ctl.run_control && !sfr.wr
                     |=> {st_r.count_hi_byte, st_r.count_lo_byte}
                         == $past({st_r.count_hi_byte, st_r.count_lo_byte}))
    else $error("16-bit count moved while halted");

  a_sysclk_count:
    assert property (!st_r.ctl.split_mode_enable && st_r.ctl.run_control
                     && st_r.clk_sel.lo_byte_clock_select && !sfr.wr
                     && st_r.count_lo_byte != BYTE_MAX
                     |=> st_r.count_lo_byte == $past(st_r.count_lo_byte) + 8'h01)
    else $error("system clock select did not count every cycle");

  a_split_hi_reload:
    assert property (st_r.ctl.split_mode_enable && !st_r.ctl.frame_capture_enable
                     && st_r.ctl.run_control && hi_tick && !sfr.wr
                     && st_r.count_hi_byte == BYTE_MAX
                     |=> st_r.count_hi_byte == $past(st_r.reload_hi_byte)
                         && st_r.ctl.hi_overflow_flag)
    else $error("split high byte did not reload or flag");

  a_capture_wrap:
    assert property (st_r.ctl.split_mode_enable && st_r.ctl.frame_capture_enable
                     && lo_tick && !sfr.wr && st_r.count_lo_byte == BYTE_MAX
                     |=> st_r.count_lo_byte == 8'h00 && st_r.ctl.lo_overflow_flag)
    else $error("capture split low byte did not wrap to zero");

  a_capture_flag:
    assert property (st_r.ctl.frame_capture_enable && sof_pulse
                     |=> st_r.ctl.hi_overflow_flag)
    else $error("frame capture did not raise the high flag");

  a_lo_flag_sticky:
    assert property (st_r.ctl.lo_overflow_flag && !wr_hit(sfr, ADDR_CTL)
                     |=> st_r.ctl.lo_overflow_flag)
    else $error("low flag cleared by hardware");

  a_div4_spacing:
    assert property (st_r.div4_tick |=> !st_r.div4_tick [*3] ##1 st_r.div4_tick)
    else $error("divide by 4 enable not spaced by 4 cycles");

  a_ext8_spacing:
    assert property (st_r.ext8_tick |=> !st_r.ext8_tick [*8])
    else $error("external divide by 8 enable came too soon");

  a_t1_pin_mode:
    assert property (timer_one_counter_mode |=> !ticks.t1)
    else $error("timer 1 enable driven in pin counting mode");

  a_t3_hi_sysclk:
    assert property (third_timer_split && st_r.clk_sel.third_timer_hi_clock_select
                     |=> ticks.t3_hi)
    else $error("Timer 3 high byte not on system clock");

endmodule

// File: tb/sfr_host_model.sv
// Bus master and frame detector model facing the Timer 2 block
`timescale 1ns/100ps
module sfr_host_model
  import timer2_pkg::*;
(
  // Clock
  input  wire logic       mclk,
  // Register bus
  output sfr_req_t        sfr,
  input  wire logic [7:0] rdata,
  // Frame detector
  output logic            sof_pulse
);

  // Idle bus and quiet frame line from time zero
  initial begin
    sfr = '0;
    sof_pulse = 1'b0;
  end

  // One-cycle write strobe; flags are only ever cleared through here
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    sfr <= '{wr: 1'b1, addr: a, wdata: d};
    @(posedge mclk);
    sfr <= '{wr: 1'b0, addr: a, wdata: ~d};
  endtask

  // Address held one cycle, data taken after the answering edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    sfr <= '{wr: 1'b0, addr: a, wdata: 8'h00};
    @(posedge mclk);
    #1 d = rdata;
  endtask

  // Single-cycle start-of-frame pulse
  task automatic sof();
    @(posedge mclk);
    sof_pulse <= 1'b1;
    @(posedge mclk);
    sof_pulse <= 1'b0;
  endtask

endmodule

// File: tb/test_timer2_reload_sof_capture.sv
// Self-checking bench for the Timer 2 block
`timescale 1ns/100ps
module test_timer2_reload_sof_capture;
  import timer2_pkg::*;

  logic       mclk, rst_n, ext_osc, timer_irq_enable, t0_pin, sof_pulse, irq;
  logic       t1_pin, t3_split;
  sfr_req_t   sfr;
  logic [7:0] rdata;
  tick_t      ticks;
  int         n_mismatch, cmp_count;

  sfr_host_model host (.mclk(mclk), .sfr(sfr), .rdata(rdata), .sof_pulse(sof_pulse));

  timer2_reload_sof_capture dut (
    .mclk(mclk), .rst_n(rst_n), .sfr(sfr), .rdata(rdata), .sof_pulse(sof_pulse),
    .ext_osc(ext_osc), .timer_irq_enable(timer_irq_enable),
    .timer_zero_counter_mode(t0_pin), .timer_one_counter_mode(t1_pin),
    .third_timer_split(t3_split), .third_timer_ext_clock_select(1'b0),
    .irq(irq), .ticks(ticks));

  // 100 MHz clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // External oscillator, eight system cycles a period
  initial begin
    ext_osc = 1'b0;
    forever begin
      repeat (4) @(posedge mclk);
      ext_osc <= ~ext_osc;
    end
  end

  task automatic end_sim();
    $display("comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Range compare; unknowns never pass
  task automatic chk(input logic [7:0] got, input logic [7:0] lo, input logic [7:0] hi);
    cmp_count++;
    if ((got >= lo) !== 1'b1 || (got <= hi) !== 1'b1) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h, expected %h..%h", $time, got, lo, hi);
    end
  endtask

  task automatic rc(input logic [7:0] a, input logic [7:0] lo, input logic [7:0] hi);
    logic [7:0] d;
    host.rd(a, d);
    chk(d, lo, hi);
  endtask

  task automatic ci(input logic e);
    #1;
    chk({7'h00, irq}, {7'h00, e}, {7'h00, e});
  endtask

  task automatic count_ticks(output int c0, output int c1, output int c2, output int c3);
    c0 = 0;
    c1 = 0;
    c2 = 0;
    c3 = 0;
    repeat (192) begin
      @(posedge mclk);
      #1;
      c0 += int'(ticks.t0 === 1'b1);
      c1 += int'(ticks.t1 === 1'b1);
      c2 += int'(ticks.t3_hi === 1'b1);
      c3 += int'(ticks.t3_lo === 1'b1);
    end
  endtask

  task automatic t_regs();
    ci(1'b0);
    rc(ADDR_CLK_SEL, 8'h00, 8'h00);
    rc(ADDR_CTL, 8'h00, 8'h00);
    host.wr(ADDR_CLK_SEL, 8'hcf);
    rc(ADDR_CLK_SEL, 8'hcf, 8'hcf);
    host.wr(ADDR_CTL, 8'h02);
    rc(ADDR_CTL, 8'h00, 8'h00);
    host.wr(ADDR_RLD_HI, 8'ha5);
    rc(ADDR_RLD_HI, 8'ha5, 8'ha5);
    rc(8'h90, 8'h00, 8'h00);
    $display("test regs done");
  endtask

  task automatic t_auto16();
    @(posedge mclk);
    timer_irq_enable <= 1'b1;
    host.wr(ADDR_CLK_SEL, 8'h10);
    host.wr(ADDR_RLD_LO, 8'h34);
    host.wr(ADDR_RLD_HI, 8'h12);
    host.wr(ADDR_CNT_LO, 8'hff);
    host.wr(ADDR_CNT_HI, 8'hff);
    host.wr(ADDR_CTL, 8'h04);
    rc(ADDR_CNT_HI, 8'h12, 8'h12);
    rc(ADDR_CTL, 8'hc4, 8'hc4);
    ci(1'b1);
    rc(ADDR_CTL, 8'hc4, 8'hc4);
    host.wr(ADDR_CTL, 8'h04);
    ci(1'b0);
    host.wr(ADDR_CTL, 8'h60);
    ci(1'b1);
    host.wr(ADDR_CTL, 8'h40);
    ci(1'b0);
    host.wr(ADDR_CTL, 8'h00);
    $display("test auto16 done");
  endtask

  task automatic t_split();
    host.wr(ADDR_CLK_SEL, 8'h30);
    host.wr(ADDR_RLD_LO, 8'h80);
    host.wr(ADDR_RLD_HI, 8'h90);
    host.wr(ADDR_CNT_LO, 8'hff);
    host.wr(ADDR_CNT_HI, 8'hfe);
    host.wr(ADDR_CTL, 8'h08);
    rc(ADDR_CNT_HI, 8'hfe, 8'hfe);
    rc(ADDR_CNT_LO, 8'h80, 8'h8f);
    rc(ADDR_CTL, 8'h48, 8'h48);
    host.wr(ADDR_CTL, 8'h0c);
    rc(ADDR_CNT_HI, 8'hff, 8'hff);
    rc(ADDR_CTL, 8'h8c, 8'h8c);
    rc(ADDR_CNT_HI, 8'h90, 8'h9f);
    host.wr(ADDR_CNT_LO, 8'hfe);
    host.wr(ADDR_CTL, 8'h08);
    rc(ADDR_CTL, 8'h48, 8'h48);
    host.wr(ADDR_CTL, 8'h00);
    $display("test split done");
  endtask

  task automatic t_clksel();
    host.wr(ADDR_CLK_SEL, 8'h20);
    host.wr(ADDR_CNT_LO, 8'h00);
    host.wr(ADDR_CNT_HI, 8'h00);
    host.wr(ADDR_CTL, 8'h04);
    repeat (120) @(posedge mclk);
    host.wr(ADDR_CTL, 8'h00);
    rc(ADDR_CNT_LO, 8'h09, 8'h0b);
    host.wr(ADDR_CNT_LO, 8'h00);
    host.wr(ADDR_CTL, 8'h05);
    repeat (256) @(posedge mclk);
    host.wr(ADDR_CTL, 8'h00);
    rc(ADDR_CNT_LO, 8'h03, 8'h05);
    $display("test clksel done");
  endtask

  task automatic t_capture();
    host.wr(ADDR_CLK_SEL, 8'h10);
    host.wr(ADDR_CNT_LO, 8'h00);
    host.wr(ADDR_CNT_HI, 8'h12);
    host.wr(ADDR_CTL, 8'h14);
    host.sof();
    ci(1'b1);
    rc(ADDR_RLD_HI, 8'h12, 8'h12);
    rc(ADDR_RLD_LO, 8'h00, 8'h08);
    rc(ADDR_CTL, 8'h94, 8'h94);
    host.wr(ADDR_CTL, 8'h00);
    host.wr(ADDR_RLD_LO, 8'h80);
    host.wr(ADDR_CNT_LO, 8'hf8);
    host.wr(ADDR_CNT_HI, 8'h55);
    host.wr(ADDR_CTL, 8'h1c);
    repeat (12) @(posedge mclk);
    host.sof();
    rc(ADDR_RLD_LO, 8'h00, 8'h10);
    rc(ADDR_RLD_HI, 8'h56, 8'h6f);
    host.wr(ADDR_CTL, 8'h00);
    $display("test capture done");
  endtask

  task automatic t_ticks();
    int div [4] = '{12, 4, 48, 64};
    int c0, c1, c2, c3;
    for (int k = 0; k < 4; k++) begin
      host.wr(ADDR_CLK_SEL, {6'h00, 2'(k)});
      count_ticks(c0, c1, c2, c3);
      chk(8'(c0), 8'(192 / div[k] - 1), 8'(192 / div[k] + 1));
      chk(8'(c1), 8'(192 / div[k] - 1), 8'(192 / div[k] + 1));
    end
    host.wr(ADDR_CLK_SEL, 8'hc4);
    count_ticks(c0, c1, c2, c3);
    chk(8'(c0), 8'd192, 8'd192);
    chk(8'(c1), 8'd15, 8'd17);
    chk(8'(c2), 8'd192, 8'd192);
    chk(8'(c3), 8'd192, 8'd192);
    @(posedge mclk);
    t3_split <= 1'b1;
    host.wr(ADDR_CLK_SEL, 8'h84);
    count_ticks(c0, c1, c2, c3);
    chk(8'(c2), 8'd192, 8'd192);
    chk(8'(c3), 8'd15, 8'd17);
    @(posedge mclk);
    t0_pin <= 1'b1;
    t1_pin <= 1'b1;
    count_ticks(c0, c1, c2, c3);
    chk(8'(c0), 8'd0, 8'd0);
    chk(8'(c1), 8'd0, 8'd0);
    $display("test ticks done");
  endtask

  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge mclk);
    n_mismatch++;
    $display("mismatch at %0t: watchdog expired", $time);
    end_sim();
  end

  // Reset, then the scenarios in turn
  initial begin
    n_mismatch = 0;
    cmp_count = 0;
    rst_n = 1'b0;
    timer_irq_enable = 1'b0;
    t0_pin = 1'b0;
    t1_pin = 1'b0;
    t3_split = 1'b0;
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    t_regs();
    t_auto16();
    t_split();
    t_clksel();
    t_capture();
    t_ticks();
    end_sim();
  end

endmodule
